// [verilog/tsic_top.sv]
// Summary of operation
// (RULE1) Address fault event sets the address fault flag; otherwise it reads zero.
// (RULE2) Stack fault event sets the stack fault flag; otherwise it reads zero.
// (RULE3) Clock failure event sets the clock failure flag; otherwise it reads zero.
// (RULE4) Lowest bit of the trap status register always reads zero.
// (RULE5) Global enable resets to one; clearing blocks interrupts, traps still pass. Here only ext_irq_req is blocked; irq is not gated.
// (RULE6) Writing one to the software trap bit raises a software trap.
// (RULE7) Vector table select one picks the alternate table, zero the standard.
// (RULE8) Per input polarity bit: one detects falling edge, zero rising edge.
// (RULE9) Disable status bit is one while a timed disable runs, then clears.
// (RULE10) Trap flags stay set until written zero; unimplemented bits read zero.
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tsic_map.svh"

module tsic_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic addr_fault_evt,
  input wire logic stack_fault_evt,
  input wire logic clock_fail_evt,
  input wire logic dis_start,
  input wire logic [13:0] dis_cycles,
  input wire tsic_pkg::tsic_ext_t ext_irq_pin,
  output tsic_pkg::tsic_ext_t ext_irq_req,
  output logic [2:0] hard_trap_req,
  output logic software_trap_req,
  output logic alt_vector_table_select,
  output logic global_irq_enable,
  output logic disable_instr_active,
  output logic irq
);
  import tsic_pkg::*;

  logic reg_wr;
  logic reg_rd;
  tsic_addr_t reg_addr;
  tsic_word_t reg_wdata;
  logic [31:0] reg_rdata;
  tsic_ext_t edge_seen;

  logic [2:0] trap_q;
  logic [2:0] trap_d;
  logic irq_en_q;
  logic irq_en_d;
  logic soft_trap_q;
  logic soft_trap_d;
  logic aivt_q;
  logic aivt_d;
  tsic_ext_t pol_q;
  tsic_ext_t pol_d;
  logic [13:0] dis_cnt_q;
  logic [13:0] dis_cnt_d;
  tsic_event_t stat_q;
  tsic_event_t stat_d;
  tsic_event_t mask_q;
  tsic_event_t mask_d;
  tsic_ext_t ext_req_q;
  tsic_ext_t ext_req_d;
  logic [2:0] trap_req_q;
  logic [2:0] trap_req_d;
  logic [2:0] trap_evt;
  tsic_event_t events;
  tsic_word_t trap_word;
  tsic_word_t ictl2_word;
  logic wr_trap;
  logic wr_ictl2;
  logic wr_stat;
  logic wr_mask;

  tsic_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  tsic_edge_detect u_edges (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(ext_irq_pin),
    .falling_sel(pol_q),
    .edge_seen(edge_seen)
  );

  assign wr_trap = reg_wr & (reg_addr == `TSIC_OFS_TRAP);
  assign wr_ictl2 = reg_wr & (reg_addr == `TSIC_OFS_ICTL2);
  assign wr_stat = reg_wr & (reg_addr == `TSIC_OFS_ISTAT);
  assign wr_mask = reg_wr & (reg_addr == `TSIC_OFS_IMASK);
  assign trap_evt = {addr_fault_evt, stack_fault_evt, clock_fail_evt};

  assign disable_instr_active = (dis_cnt_q != 14'h0000); // RULE9
  assign global_irq_enable = irq_en_q;
  assign software_trap_req = soft_trap_q; // RULE6
  assign alt_vector_table_select = aivt_q; // RULE7
  assign ext_irq_req = ext_req_q;
  assign hard_trap_req = trap_req_q;
  assign irq = |(stat_q & mask_q);

  always_comb begin
    events = 8'h00;
    events[`TSIC_IST_EXT_MSB:`TSIC_IST_EXT_LSB] = edge_seen;
    events[`TSIC_IST_ADDR_BIT] = addr_fault_evt;
    events[`TSIC_IST_STK_BIT] = stack_fault_evt;
    events[`TSIC_IST_CLK_BIT] = clock_fail_evt;
    // Decoded from the write itself so this process does not lean on the next one.
    events[`TSIC_IST_SW_BIT] = wr_ictl2 & reg_wdata[`TSIC_ICTL2_SOFTTRAP_BIT] & ~soft_trap_q;
  end

  always_comb begin
    trap_d = trap_q;
    irq_en_d = irq_en_q;
    soft_trap_d = soft_trap_q;
    aivt_d = aivt_q;
    pol_d = pol_q;
    mask_d = mask_q;
    stat_d = stat_q;
    dis_cnt_d = dis_cnt_q;
    // Writing one to a trap flag does nothing; a new event beats the clear.
    if (wr_trap) begin
      trap_d = trap_q & reg_wdata[`TSIC_TRAP_ADDR_BIT:`TSIC_TRAP_CLK_BIT]; // RULE10
    end
    trap_d = trap_d | trap_evt; // RULE1 RULE2 RULE3
    if (wr_ictl2) begin
      irq_en_d = reg_wdata[`TSIC_ICTL2_IRQEN_BIT];
      soft_trap_d = reg_wdata[`TSIC_ICTL2_SOFTTRAP_BIT]; // RULE6
      aivt_d = reg_wdata[`TSIC_ICTL2_AIVT_BIT]; // RULE7
      pol_d = reg_wdata[`TSIC_ICTL2_POL_MSB:`TSIC_ICTL2_POL_LSB]; // RULE8
    end
    if (wr_mask) begin
      mask_d = reg_wdata[7:0];
    end
    if (wr_stat) begin
      stat_d = stat_q & ~reg_wdata[7:0];
    end
    stat_d = stat_d | events;
    if (dis_start && (dis_cycles != 14'h0000)) begin
      dis_cnt_d = dis_cycles; // RULE9
    end else if (dis_cnt_q != 14'h0000) begin
      dis_cnt_d = dis_cnt_q - 14'h0001;
    end
    // External requests are held off by the global enable and a running disable; irq is not.
    ext_req_d = edge_seen & {4{irq_en_q & ~disable_instr_active}}; // RULE5
    trap_req_d = trap_evt; // RULE5
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap_q <= `TSIC_TRAP_RST;
      irq_en_q <= `TSIC_IRQEN_RST; // RULE5
      soft_trap_q <= 1'h0;
      aivt_q <= 1'h0;
      pol_q <= `TSIC_POL_RST;
      mask_q <= `TSIC_IMASK_RST;
      stat_q <= `TSIC_IST_RST;
      dis_cnt_q <= `TSIC_DIS_RST;
      ext_req_q <= 4'h0;
      trap_req_q <= 3'h0;
    end else begin
      trap_q <= trap_d;
      irq_en_q <= irq_en_d;
      soft_trap_q <= soft_trap_d;
      aivt_q <= aivt_d;
      pol_q <= pol_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      dis_cnt_q <= dis_cnt_d;
      ext_req_q <= ext_req_d;
      trap_req_q <= trap_req_d;
    end
  end

  always_comb begin
    trap_word = 16'h0000;
    trap_word[`TSIC_TRAP_ADDR_BIT:`TSIC_TRAP_CLK_BIT] = trap_q; // RULE4 RULE10
    ictl2_word = 16'h0000;
    ictl2_word[`TSIC_ICTL2_IRQEN_BIT] = irq_en_q;
    ictl2_word[`TSIC_ICTL2_DIS_BIT] = disable_instr_active;
    ictl2_word[`TSIC_ICTL2_SOFTTRAP_BIT] = soft_trap_q;
    ictl2_word[`TSIC_ICTL2_AIVT_BIT] = aivt_q;
    ictl2_word[`TSIC_ICTL2_POL_MSB:`TSIC_ICTL2_POL_LSB] = pol_q;
    unique case (reg_addr)
      `TSIC_OFS_TRAP: reg_rdata = {16'h0000, trap_word};
      `TSIC_OFS_ICTL2: reg_rdata = {16'h0000, ictl2_word};
      `TSIC_OFS_ISTAT: reg_rdata = {24'h000000, stat_q};
      `TSIC_OFS_IMASK: reg_rdata = {24'h000000, mask_q};
      default: reg_rdata = 32'h00000000;
    endcase
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A clear written in the cycle after the event may legally drop the flag again.
  chk_addr_flag_set: assert property (addr_fault_evt // RULE1
      |=> trap_q[2] ##1 (trap_q[2] || $past(wr_trap)))
    else $error("Address fault flag not set and held.");
  chk_stack_flag_set: assert property (stack_fault_evt |=> trap_q[1]) // RULE2
    else $error("Stack fault flag not set.");
  chk_clock_flag_set: assert property (clock_fail_evt |=> trap_q[0]) // RULE3
    else $error("Clock failure flag not set.");
  chk_flag_needs_event: assert property ($rose(trap_q[2]) |-> $past(addr_fault_evt)) // RULE1
    else $error("Address fault flag rose without an event.");
  chk_bit0_reads_zero: assert property (reg_rd && reg_addr == `TSIC_OFS_TRAP // RULE4
      |=> hrdata[0] == 1'b0 && hrdata[31:4] == 28'h0000000)
    else $error("Unimplemented trap bits read nonzero.");
  chk_enable_blocks_irq: assert property (!irq_en_q |=> ext_irq_req == 4'h0) // RULE5
    else $error("External request passed while disabled.");
  chk_trap_ignores_gie: assert property (addr_fault_evt |=> hard_trap_req[2]) // RULE5
    else $error("Trap request lost.");
  chk_soft_trap_raise: assert property (wr_ictl2 && reg_wdata[13] // RULE6
      |=> software_trap_req && (stat_q[7] || $past(soft_trap_q)))
    else $error("Software trap not raised.");
  chk_alt_vector: assert property (wr_ictl2 |=> alt_vector_table_select == $past(reg_wdata[8])) // RULE7
    else $error("Vector table select not taken.");
  chk_fall_detect: assert property ($past(ext_irq_pin[0]) && !ext_irq_pin[0] && pol_q[0] // RULE8
      && irq_en_q && !disable_instr_active |=> ext_irq_req[0])
    else $error("Falling edge not detected.");
  chk_rise_detect: assert property (!$past(ext_irq_pin[1]) && ext_irq_pin[1] && !pol_q[1] // RULE8
      && irq_en_q && !disable_instr_active |=> ext_irq_req[1])
    else $error("Rising edge not detected.");
  chk_disable_period: assert property (dis_start && dis_cycles == 14'h0005 // RULE9
      |=> disable_instr_active [*5] ##1 !disable_instr_active)
    else $error("Disable period length wrong.");
  chk_flag_sticky: assert property (trap_q[1] && !wr_trap |=> trap_q[1]) // RULE10
    else $error("Stack fault flag dropped without a clear.");

  cov_trap_clear: cover property (trap_q[2] && wr_trap ##1 !trap_q[2]);
  cov_ext_falling: cover property (pol_q[2] && ext_irq_req[2]);
  cov_disable_masked: cover property (disable_instr_active && edge_seen[0]);
  cov_irq_raised: cover property (!irq ##1 irq);

endmodule : tsic_top

`default_nettype wire

// [pkg/tsic_map.svh]
`ifndef TSIC_MAP_SVH
`define TSIC_MAP_SVH

// Register byte offsets inside the 256-byte window.
`define TSIC_OFS_TRAP 8'h00
`define TSIC_OFS_ICTL2 8'h04
`define TSIC_OFS_ISTAT 8'h08
`define TSIC_OFS_IMASK 8'h0C

// Trap status and control one: flag positions.
`define TSIC_TRAP_ADDR_BIT 3
`define TSIC_TRAP_STK_BIT 2
`define TSIC_TRAP_CLK_BIT 1
`define TSIC_TRAP_RST 3'h0

// Interrupt control two: field positions and reset value.
`define TSIC_ICTL2_IRQEN_BIT 15
`define TSIC_ICTL2_DIS_BIT 14
`define TSIC_ICTL2_SOFTTRAP_BIT 13
`define TSIC_ICTL2_AIVT_BIT 8
`define TSIC_ICTL2_POL_LSB 0
`define TSIC_ICTL2_POL_MSB 3
`define TSIC_IRQEN_RST 1'h1
`define TSIC_POL_RST 4'h0

// Event status and mask layout.
`define TSIC_IST_EXT_LSB 0
`define TSIC_IST_EXT_MSB 3
`define TSIC_IST_ADDR_BIT 4
`define TSIC_IST_STK_BIT 5
`define TSIC_IST_CLK_BIT 6
`define TSIC_IST_SW_BIT 7
`define TSIC_IST_RST 8'h00
`define TSIC_IMASK_RST 8'h00

// Timed interrupt-disable counter.
`define TSIC_DIS_W 14
`define TSIC_DIS_RST 14'h0000

`endif

// [pkg/tsic_pkg.sv]
package tsic_pkg;

  typedef enum logic [3:0] {
    TSIC_BUS_IDLE = 4'b0001,
    TSIC_BUS_WR = 4'b0010,
    TSIC_BUS_RD_WAIT = 4'b0100,
    TSIC_BUS_RD_DONE = 4'b1000
  } tsic_bus_state_t;

  typedef logic [15:0] tsic_word_t;
  typedef logic [7:0] tsic_addr_t;
  typedef logic [3:0] tsic_ext_t;
  typedef logic [7:0] tsic_event_t;

endpackage : tsic_pkg

// [verilog/tsic_edge_detect.sv]
`timescale 1ns/1ps
`default_nettype none

module tsic_edge_detect (
  input wire logic hclk,
  input wire logic hresetn,
  input wire tsic_pkg::tsic_ext_t pin,
  input wire tsic_pkg::tsic_ext_t falling_sel,
  output tsic_pkg::tsic_ext_t edge_seen
);
  import tsic_pkg::*;

  tsic_ext_t prev_q;
  tsic_ext_t prev_d;

  always_comb begin
    prev_d = pin;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // A pin already high at reset release reports one rising edge.
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pin
      assign edge_seen[i] = falling_sel[i] ? (prev_q[i] & ~pin[i]) // RULE8
                                           : (~prev_q[i] & pin[i]);
    end
  endgenerate

endmodule : tsic_edge_detect

`default_nettype wire

// [verilog/tsic_ahb_slave.sv]
`timescale 1ns/1ps
`default_nettype none

module tsic_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic reg_wr,
  output logic reg_rd,
  output tsic_pkg::tsic_addr_t reg_addr,
  output tsic_pkg::tsic_word_t reg_wdata,
  input wire logic [31:0] reg_rdata
);
  import tsic_pkg::*;

  tsic_bus_state_t state_q;
  tsic_bus_state_t state_d;
  tsic_addr_t addr_q;
  tsic_addr_t addr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic take;

  // Only word accesses are expected; hsize is not checked.
  assign take = hsel & htrans[1] & hready;
  assign hreadyout = (state_q != TSIC_BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign reg_addr = addr_q;
  assign reg_wdata = hwdata[15:0];
  assign reg_wr = (state_q == TSIC_BUS_WR);
  assign reg_rd = (state_q == TSIC_BUS_RD_WAIT);

  // Reads take one wait state so that a write just ahead is already visible.
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    rdata_d = rdata_q;
    if (state_q == TSIC_BUS_RD_WAIT) begin
      rdata_d = reg_rdata;
      state_d = TSIC_BUS_RD_DONE;
    end else if (take) begin
      addr_d = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
      state_d = hwrite ? TSIC_BUS_WR : TSIC_BUS_RD_WAIT;
    end else begin
      state_d = TSIC_BUS_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= TSIC_BUS_IDLE;
      addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
    end
  end

endmodule : tsic_ahb_slave

`default_nettype wire

// [tb/tsic_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Stands in for the core and the pins; outputs move only after a clock edge.
module tsic_core_model (
  input wire logic hclk,
  input wire logic [2:0] trap_cmd,
  input wire logic [14:0] dis_cmd,
  input wire logic [3:0] pin_cmd,
  output logic addr_fault_evt,
  output logic stack_fault_evt,
  output logic clock_fail_evt,
  output logic dis_start,
  output logic [13:0] dis_cycles,
  output tsic_pkg::tsic_ext_t ext_irq_pin
);
  import tsic_pkg::*;

  always_ff @(posedge hclk) begin
    {addr_fault_evt, stack_fault_evt, clock_fail_evt} <= trap_cmd;
    {dis_start, dis_cycles} <= dis_cmd;
    ext_irq_pin <= pin_cmd;
  end
endmodule : tsic_core_model

`default_nettype wire

// [tb/tsic_top_test.sv]
`timescale 1ns/1ps
`default_nettype none

module tsic_top_test;
  import tsic_pkg::*;
  typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] r;} tsic_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic sw, alt, irq_en, dis, irq, a_e, s_e, c_e, d_st;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [13:0] d_len;
  logic [2:0] trap_cmd, htr;
  logic [14:0] dis_cmd;
  logic [3:0] pin_cmd;
  tsic_ext_t pin, ext_req;
  int miscompares, check_count, n_ext, n_trap, n_dis;
  tsic_row_t rows[7] = '{
    '{32'h4, 32'hFFFF, 32'hA10F}, '{32'h4, 32'h100, 32'h100}, '{32'h4, 32'h0, 32'h0},
    '{32'h4, 32'h8000, 32'h8000}, '{32'h0, 32'hFFFF, 32'h0}, '{32'hC, 32'h1FF, 32'hFF},
    '{32'h100, 32'hFFFF, 32'h0}};

  tsic_top i_tsic_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .addr_fault_evt(a_e),
    .stack_fault_evt(s_e), .clock_fail_evt(c_e), .dis_start(d_st), .dis_cycles(d_len),
    .ext_irq_pin(pin), .ext_irq_req(ext_req), .hard_trap_req(htr), .software_trap_req(sw),
    .alt_vector_table_select(alt), .global_irq_enable(irq_en), .disable_instr_active(dis),
    .irq(irq));

  tsic_core_model i_tsic_core_model (.hclk(hclk), .trap_cmd(trap_cmd), .dis_cmd(dis_cmd),
    .pin_cmd(pin_cmd), .addr_fault_evt(a_e), .stack_fault_evt(s_e), .clock_fail_evt(c_e),
    .dis_start(d_st), .dis_cycles(d_len), .ext_irq_pin(pin));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk

  // No cycle count is assumed; only the watchdog ends a wait on a silent slave.
  task automatic wait_rdy;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : bus

  task automatic watch(input int cyc);
    n_ext = 0;
    n_trap = 0;
    n_dis = 0;
    repeat (cyc) begin
      @(posedge hclk);
      if (ext_req !== 4'h0) n_ext++;
      if (htr !== 3'h0) n_trap++;
      if (dis === 1'b1) n_dis++;
    end
  endtask : watch

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    repeat (5000) @(posedge hclk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    {trap_cmd, dis_cmd, pin_cmd} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h4, 32'h0);
    chk("ctl2 reset", 32'h8000, rd);
    bus(1'b0, 32'h0, 32'h0);
    chk("trap reset", 32'h0, rd);
    chk("irq reset", 32'h0, 32'(irq));
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 32'h0);
      chk("readback", rows[i].r, rd);
      if (rows[i].a == 32'h4) begin
        chk("software_trap_bit", 32'(rows[i].r[13]), 32'(sw));
        chk("altvec", 32'(rows[i].r[8]), 32'(alt));
        chk("irq enable", 32'(rows[i].r[15]), 32'(irq_en));
      end
    end
    $display("register table test done");
    bus(1'b1, 32'h8, 32'hFF);
    bus(1'b1, 32'h4, 32'h0);
    for (int i = 0; i < 3; i++) begin
      trap_cmd <= 3'h4 >> i;
      @(posedge hclk);
      trap_cmd <= 3'h0;
      watch(6);
      chk("trap pulses", 32'h1, 32'(n_trap));
    end
    bus(1'b0, 32'h0, 32'h0);
    chk("trap flags", 32'hE, rd);
    bus(1'b0, 32'h8, 32'h0);
    chk("status", 32'h70, rd);
    chk("irq set", 32'h1, 32'(irq));
    bus(1'b1, 32'h8, 32'h70);
    // The clear lands on the edge that ends the write, so look one edge later.
    @(posedge hclk);
    chk("irq clear", 32'h0, 32'(irq));
    bus(1'b0, 32'h0, 32'h0);
    chk("flags sticky", 32'hE, rd);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b0, 32'h0, 32'h0);
    chk("flags cleared", 32'h0, rd);
    $display("trap test done");
    bus(1'b1, 32'h4, 32'h8000);
    pin_cmd <= 4'hF;
    watch(6);
    chk("rising edge", 32'h1, 32'(n_ext));
    bus(1'b1, 32'h4, 32'h800F);
    pin_cmd <= 4'h0;
    watch(6);
    chk("falling edge", 32'h1, 32'(n_ext));
    pin_cmd <= 4'hF;
    watch(6);
    chk("rise ignored", 32'h0, 32'(n_ext));
    bus(1'b1, 32'h4, 32'h000F);
    bus(1'b1, 32'h8, 32'hFF);
    pin_cmd <= 4'h0;
    watch(6);
    chk("gated edge", 32'h0, 32'(n_ext));
    bus(1'b0, 32'h8, 32'h0);
    chk("gated status", 32'hF, rd);
    $display("edge test done");
    bus(1'b1, 32'h4, 32'h8000);
    dis_cmd <= {1'b1, 14'h5};
    @(posedge hclk);
    dis_cmd <= 15'h0;
    watch(10);
    chk("disable length", 32'h5, 32'(n_dis));
    dis_cmd <= {1'b1, 14'h28};
    @(posedge hclk);
    dis_cmd <= 15'h0;
    bus(1'b0, 32'h4, 32'h0);
    chk("disable status", 32'hC000, rd);
    pin_cmd <= 4'hF;
    watch(6);
    chk("disabled edge", 32'h0, 32'(n_ext));
    watch(40);
    bus(1'b0, 32'h4, 32'h0);
    chk("disable over", 32'h8000, rd);
    $display("disable test done");
    tally_and_finish();
  end
endmodule : tsic_top_test

`default_nettype wire
